// File: common/ref_diag_consts.svh
// constants for the reference-detect diagnostic block
`ifndef REF_DIAG_CONSTS_SVH
`define REF_DIAG_CONSTS_SVH
// register byte offsets
`define OFF_CTRL 4'h0
`define OFF_ERROR 4'h4
`define OFF_STATUS 4'h8
`define OFF_RESULT 4'hC
// ctrl fields
`define CTRL_CHECK_EN_BIT 0
`define CTRL_EXT_REF_BIT 1
`define CTRL_TEST_SRC_BIT 2
`define CTRL_RESET 32'h0000_0000
// error and status fields
`define ERROR_REF_LOSS_BIT 0
`define STATUS_ERR_BIT 7
// reference threshold in millivolts (0.3 V)
`define REF_MIN_MV 16'd300
// test source level in millivolts
`define TEST_SRC_MV 16'd20
`endif

// File: common/ref_diag_pkg.sv
// types for the reference-detect diagnostic block
package ref_diag_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_CAL = 2'b10
    } op_state_t;
endpackage : ref_diag_pkg

// File: hdl/sync3.sv
// three-stage synchroniser with agreement of the last two stages
`timescale 1ns/10ps
module sync3 #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    // ----------------------------------------
    // stages
    // ----------------------------------------
    logic [W-1:0] s1; // first stage, read only by s2
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
    logic [W-1:0] next_q;

    // output moves only when stages two and three agree
    always_comb begin
        for (int i = 0; i < W; i++) begin
            next_q[i] = (s2[i] == s3[i]) ? s3[i] : q[i];
        end
    end

    // registers only
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            q <= '0;
        end else begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
            q <= next_q;
        end
    end

    assign q_o = q;
endmodule : sync3

// File: hdl/ref_diag.sv
// reference-loss detection, result forcing and calibration guard
// Notes on behaviour
// - detection only when enabled and external reference
// - flag sets on low or open reference
// - flag also sets status summary error bit
// - conversion results forced all ones on error
// - calibration coefficient write suppressed on error
// - flag possible after standby; error read clears
// - internal 20 mV test source selectable
// - flags cleared only by error register read
`timescale 1ns/10ps
`include "ref_diag_consts.svh"
module ref_diag
    import ref_diag_pkg::*;
#(
    parameter int DATA_W = 24
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    // avalon-mm slave
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // comparator pins from the reference monitor
    input wire logic ref_below_min_i,
    input wire logic ext_ref_pos_open_i,
    input wire logic ext_ref_neg_open_i,
    // converter datapath
    input wire logic conv_valid_i,
    input wire logic [DATA_W-1:0] conv_data_i,
    input wire logic cal_active_i,
    input wire logic cal_done_i,
    input wire logic [DATA_W-1:0] cal_coef_i,
    input wire logic standby_exit_i,
    output logic [DATA_W-1:0] result_o,
    output logic result_valid_o,
    output logic [DATA_W-1:0] cal_coef_o,
    output logic cal_coef_we_o,
    output logic test_source_pos_o,
    output logic test_source_neg_o
);
    // ----------------------------------------
    // pin synchronisation
    // ----------------------------------------
    logic [2:0] pins_raw; // raw comparator levels
    logic [2:0] pins_s; // synchronised comparator levels
    assign pins_raw = {ext_ref_neg_open_i, ext_ref_pos_open_i, ref_below_min_i};

    sync3 #(.W(3)) u_sync (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .d_i(pins_raw),
        .q_o(pins_s)
    );

    // ----------------------------------------
    // register state
    // ----------------------------------------
    logic [2:0] ctrl; // check enable, external ref, test source
    logic [2:0] next_ctrl;
    logic ref_loss_flag; // sticky reference-loss flag
    logic next_ref_loss_flag;
    logic [31:0] rdata; // registered read data
    logic [31:0] next_rdata;
    logic ack; // answer phase of an access
    logic next_ack;
    logic [DATA_W-1:0] result; // last delivered result
    logic [DATA_W-1:0] next_result;
    logic result_valid;
    logic next_result_valid;
    logic [DATA_W-1:0] cal_coef;
    logic [DATA_W-1:0] next_cal_coef;
    logic cal_we;
    logic next_cal_we;

    logic ref_loss_check_enable; // ctrl bit 0
    logic ext_ref_sel; // ctrl bit 1
    logic loss_now; // live loss condition while checking
    logic err_read; // error register read taken this cycle
    logic access; // any access in its answer cycle

    assign ref_loss_check_enable = ctrl[`CTRL_CHECK_EN_BIT];
    assign ext_ref_sel = ctrl[`CTRL_EXT_REF_BIT];
    // detection runs only with enable and an external reference selected
    assign loss_now = ref_loss_check_enable && ext_ref_sel && (|pins_s);
    // every access takes one wait cycle, answered on the second edge
    assign access = (avs_read_i || avs_write_i) && ack;
    assign err_read = avs_read_i && ack && (avs_address_i == `OFF_ERROR);

    // ----------------------------------------
    // register file and flag next state
    // ----------------------------------------
    always_comb begin
        next_ctrl = ctrl;
        next_rdata = rdata;
        next_ack = 1'b0;
        next_ref_loss_flag = ref_loss_flag;
        // first cycle of a request raises ack; the answer cycle drops it
        if ((avs_read_i || avs_write_i) && !ack) begin
            next_ack = 1'b1;
        end
        if (avs_write_i && ack && avs_address_i == `OFF_CTRL) begin
            next_ctrl = avs_writedata_i[2:0];
        end
        // read clears, the only way to clear; a new loss wins over the clear
        if (err_read) begin
            next_ref_loss_flag = 1'b0;
        end
        // sticky: recovery of the reference never clears it
        if (loss_now) begin
            next_ref_loss_flag = 1'b1;
        end
        // read data prepared in the wait cycle
        if (avs_read_i && !ack) begin
            unique case (avs_address_i)
                `OFF_CTRL: next_rdata = {29'h0, ctrl};
                // a loss seen in this wait cycle is reported too, as the answer cycle clears the flag
                `OFF_ERROR: next_rdata = {31'h0, ref_loss_flag || loss_now};
                // summary error mirrors the flag
                `OFF_STATUS: next_rdata = {24'h0, ref_loss_flag, 7'h0};
                `OFF_RESULT: next_rdata = 32'(result);
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // datapath next state
    // ----------------------------------------
    always_comb begin
        next_result = result;
        next_result_valid = conv_valid_i;
        next_cal_we = 1'b0;
        next_cal_coef = cal_coef;
        if (conv_valid_i) begin
            // error turns the result into all ones so the host can spot it
            next_result = (ref_loss_flag || loss_now) ? {DATA_W{1'b1}} : conv_data_i;
        end
        if (cal_active_i && cal_done_i) begin
            next_cal_coef = cal_coef_i;
            // bad coefficients are still latched into cal_coef, but their write strobe cal_we stays low
            next_cal_we = !(ref_loss_flag || loss_now);
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl <= 3'h0;
            ref_loss_flag <= 1'b0;
            rdata <= 32'h0000_0000;
            ack <= 1'b0;
            result <= '0;
            result_valid <= 1'b0;
            cal_coef <= '0;
            cal_we <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            ref_loss_flag <= next_ref_loss_flag;
            rdata <= next_rdata;
            ack <= next_ack;
            result <= next_result;
            result_valid <= next_result_valid;
            cal_coef <= next_cal_coef;
            cal_we <= next_cal_we;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign avs_readdata_o = rdata;
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;
    assign result_o = result;
    assign result_valid_o = result_valid;
    assign cal_coef_o = cal_coef;
    assign cal_coef_we_o = cal_we;
    // internal test pair routed to the channel input on request
    assign test_source_pos_o = ctrl[`CTRL_TEST_SRC_BIT];
    assign test_source_neg_o = ctrl[`CTRL_TEST_SRC_BIT];

    // ----------------------------------------
    // converter activity tracking
    // ----------------------------------------
    // what the converter is busy with, so the checks can tell a
    // calibration answer from a conversion word
    op_state_t op_state;
    op_state_t next_op_state;

    // calibration outranks conversion; a loss at standby exit is latched like any other
    always_comb begin
        next_op_state = op_state;
        unique case (op_state)
            ST_IDLE: begin
                if (cal_active_i) begin
                    next_op_state = ST_CAL;
                end else if (conv_valid_i) begin
                    next_op_state = ST_CONV;
                end
            end
            ST_CONV: begin
                // a calibration request interrupts the conversion stream
                if (cal_active_i) begin
                    next_op_state = ST_CAL;
                end
            end
            ST_CAL: begin
                // coefficient handed over or run abandoned
                if (!cal_active_i) begin
                    next_op_state = ST_IDLE;
                end
            end
            // the fourth code is never entered; recover to idle
            default: next_op_state = ST_IDLE;
        endcase
        // standby exit restarts the tracking from idle
        if (standby_exit_i) begin
            next_op_state = ST_IDLE;
        end
    end

    // state register only
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            op_state <= ST_IDLE;
        end else begin
            op_state <= next_op_state;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_flag_sets_on_loss: assert property (@(posedge clk_i) disable iff (!resetn_i)
        loss_now |=> ref_loss_flag)
        else $error("flag not set after loss");

    a_no_check_disabled: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (!ref_loss_flag && !(ref_loss_check_enable && ext_ref_sel)) |=> !ref_loss_flag)
        else $error("flag set while detection off");

    a_flag_sticky: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (ref_loss_flag && !err_read) |=> ref_loss_flag)
        else $error("flag dropped without read");

    a_clear_by_read: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $fell(ref_loss_flag) |-> $past(err_read) && !$past(loss_now))
        else $error("flag cleared without error read");

    a_read_clears: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (err_read && !loss_now) |=> !ref_loss_flag)
        else $error("error read did not clear flag");

    a_status_summary: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (avs_read_i && !ack && avs_address_i == `OFF_STATUS) |=> rdata[`STATUS_ERR_BIT] == $past(ref_loss_flag))
        else $error("status summary bit wrong");

    a_result_ones: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (conv_valid_i && ref_loss_flag) |=> result_valid && (&result))
        else $error("result not forced to ones");

    a_cal_blocked: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (cal_active_i && cal_done_i && ref_loss_flag && !err_read) |=> !cal_we ##0 ref_loss_flag)
        else $error("coefficient written during ref loss");

    a_test_pair: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (avs_write_i && ack && avs_address_i == `OFF_CTRL)
            |=> test_source_pos_o == $past(avs_writedata_i[`CTRL_TEST_SRC_BIT]) && test_source_neg_o == test_source_pos_o)
        else $error("test source routing wrong");

    a_single_wait: assert property (@(posedge clk_i) disable iff (!resetn_i)
        access |=> !ack)
        else $error("access held more than one wait cycle");

    a_result_pass: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (conv_valid_i && !ref_loss_flag && !loss_now) |=> result == $past(conv_data_i))
        else $error("clean result altered");

    a_valid_pulse: assert property (@(posedge clk_i) disable iff (!resetn_i)
        conv_valid_i |=> result_valid)
        else $error("result valid missing");

    a_cal_pass: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (cal_active_i && cal_done_i && !ref_loss_flag && !loss_now) |=> cal_we && cal_coef == $past(cal_coef_i))
        else $error("clean coefficient not written");

    a_ctrl_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (avs_write_i && ack && avs_address_i == `OFF_CTRL) |=> ctrl == $past(avs_writedata_i[2:0]))
        else $error("control write lost");

    a_err_readback: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (avs_read_i && !ack && avs_address_i == `OFF_ERROR)
            |=> rdata[`ERROR_REF_LOSS_BIT] == $past(ref_loss_flag || loss_now))
        else $error("error register read back wrong");

    a_standby_keeps: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (standby_exit_i && ref_loss_flag && !err_read) |=> ref_loss_flag)
        else $error("standby exit cleared flag");

    a_cal_state: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (cal_active_i && !standby_exit_i) |=> op_state == ST_CAL)
        else $error("calibration not tracked");
endmodule : ref_diag

// File: test/host_model.sv
// host-side bus master model for the diagnostic registers
`timescale 1ns/10ps
module host_model (
    input wire logic clk_i,
    input wire logic [31:0] rdata_i,
    input wire logic wait_i,
    output logic [3:0] addr_o,
    output logic rd_o,
    output logic wr_o,
    output logic [31:0] wdata_o
);
    // bus idle at time zero
    initial begin
        addr_o = 4'h0;
        rd_o = 1'b0;
        wr_o = 1'b0;
        wdata_o = 32'h0000_0000;
    end
    // one access, held until waitrequest is seen low; error reads clear the flag
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        addr_o <= a;
        wr_o <= w;
        rd_o <= !w;
        wdata_o <= d;
        // only the bench watchdog ends a wait that never answers
        do begin
            @(posedge clk_i);
        end while (wait_i !== 1'b0);
        q = rdata_i;
        rd_o <= 1'b0;
        wr_o <= 1'b0;
        wdata_o <= ~d; // released data must not look valid
    endtask : acc
endmodule : host_model

// File: test/testbench.sv
// self-checking bench for the reference-detect diagnostic block
`timescale 1ns/10ps
`include "ref_diag_consts.svh"
module testbench;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [3:0] addr;
    logic rd;
    logic wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic wreq;
    logic [2:0] pins = 3'b000; // open neg, open pos, below min
    logic cvalid = 1'b0;
    logic cact = 1'b0;
    logic cdone = 1'b0;
    logic stby = 1'b0; // standby exit pulse
    logic [23:0] cdata = 24'h00_0000;
    logic [23:0] ccoef = 24'h00_0000;
    logic [23:0] res;
    logic [23:0] coef;
    logic rvalid;
    logic cwe;
    logic tp;
    logic tn;
    logic [31:0] q;
    logic [23:0] rq[$]; // expected results
    logic [23:0] cq[$]; // expected coefficient writes
    int num_errors = 0;
    int num_checks = 0;
    integer seed = 98652;
    always #2.5 clk_i = ~clk_i;
    host_model host_u (.clk_i(clk_i), .rdata_i(rdata), .wait_i(wreq), .addr_o(addr), .rd_o(rd), .wr_o(wr),
        .wdata_o(wdata));
    ref_diag #(.DATA_W(24)) dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
        .ref_below_min_i(pins[0]), .ext_ref_pos_open_i(pins[1]), .ext_ref_neg_open_i(pins[2]),
        .conv_valid_i(cvalid), .conv_data_i(cdata), .cal_active_i(cact), .cal_done_i(cdone),
        .cal_coef_i(ccoef), .standby_exit_i(stby), .result_o(res), .result_valid_o(rvalid),
        .cal_coef_o(coef), .cal_coef_we_o(cwe), .test_source_pos_o(tp), .test_source_neg_o(tn));
    // compare one value and count it
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test;
        chk(rq.size() + cq.size(), 32'h0000_0000);
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    task automatic rg(input logic [3:0] a, input logic [31:0] e);
        host_u.acc(1'b0, a, 32'h0000_0000, q);
        chk(q, e);
    endtask : rg
    task automatic wc(input logic [31:0] d);
        host_u.acc(1'b1, `OFF_CTRL, d, q);
    endtask : wc
    // loss on one pin long enough to pass the synchroniser, then recovery
    task automatic loss(input int k);
        @(posedge clk_i);
        pins <= 3'b001 << k;
        repeat (8) @(posedge clk_i);
        pins <= 3'b000;
        repeat (8) @(posedge clk_i);
    endtask : loss
    // one random conversion word; all ones expected while the flag stands
    task automatic conv(input logic lost);
        logic [23:0] d;
        d = 24'($random(seed));
        @(posedge clk_i);
        cvalid <= 1'b1;
        cdata <= d;
        rq.push_back(lost ? 24'hFF_FFFF : d);
        @(posedge clk_i);
        cvalid <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask : conv
    // calibration; a loss raised as the run starts must block the coefficient write
    task automatic cal(input logic lost);
        logic [23:0] d;
        d = 24'($random(seed));
        @(posedge clk_i);
        cact <= 1'b1;
        pins <= {2'b00, lost};
        repeat (8) @(posedge clk_i);
        cdone <= 1'b1;
        ccoef <= d;
        if (!lost) cq.push_back(d);
        @(posedge clk_i);
        cdone <= 1'b0;
        cact <= 1'b0;
        pins <= 3'b000;
        repeat (8) @(posedge clk_i);
    endtask : cal
    // ----------------------------------------
    // monitor: oldest note against each result
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (rvalid === 1'b1) chk(res, rq.pop_front());
        if (cwe === 1'b1) chk(coef, cq.pop_front());
    end
    // watchdog, well past the expected run length
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        end_of_test();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk_i);
        resetn_i <= 1'b1;
        rg(`OFF_CTRL, 32'h0000_0000);
        rg(`OFF_ERROR, 32'h0000_0000);
        host_u.acc(1'b1, 4'h2, 32'hFFFF_FFFF, q);
        rg(4'h2, 32'h0000_0000);
        $display("reset test done");
        wc(32'h0000_0001);
        loss(0);
        rg(`OFF_ERROR, 32'h0000_0000);
        wc(32'h0000_0002);
        loss(1);
        rg(`OFF_ERROR, 32'h0000_0000);
        conv(1'b0);
        $display("gating test done");
        wc(32'h0000_0003);
        for (int k = 0; k < 3; k++) begin
            conv(1'b0);
            loss(k);
            conv(1'b1);
            rg(`OFF_STATUS, 32'h0000_0080);
            rg(`OFF_ERROR, 32'h0000_0001);
            rg(`OFF_ERROR, 32'h0000_0000);
            rg(`OFF_STATUS, 32'h0000_0000);
        end
        cal(1'b0);
        rg(`OFF_ERROR, 32'h0000_0000);
        cal(1'b1);
        rg(`OFF_ERROR, 32'h0000_0001);
        // loss latched, then standby exit; the read after it must clear
        loss(2);
        @(posedge clk_i);
        stby <= 1'b1;
        @(posedge clk_i);
        stby <= 1'b0;
        rg(`OFF_ERROR, 32'h0000_0001);
        rg(`OFF_ERROR, 32'h0000_0000);
        $display("loss test done");
        wc(32'h0000_0007);
        #1;
        chk({tp, tn}, 2'b11);
        wc(32'h0000_0003);
        #1;
        chk({tp, tn}, 2'b00);
        $display("test source done");
        end_of_test();
    end
endmodule : testbench
